// [src/reset_halt_sequencer.sv]
// Reset and standby sequencer for a small remote-control microcontroller.
// Assumes key inputs are active low with pull-ups and synchronous to clock,
// and that the CPU advances only while cpu_run is high.
`timescale 1ns/10ps

module reset_halt_sequencer #(
   parameter bit CARRIER_FLOATS = 1'b0,
   parameter int AUTO_RESET_CYCLES = reset_halt_pkg::AUTO_RESET_OSC_CYCLES,
   parameter int STAB_CYCLES = reset_halt_pkg::STAB_CYCLES
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic power_on_request,
   input wire logic tx_activity_bit,
   input wire logic halt_request_bit,
   input wire logic [3:0] key_input_group_a_n,
   input wire logic [3:0] key_input_group_b_n,
   input wire reset_halt_pkg::output_pins_type cpu_pins,
   output reset_halt_pkg::output_pins_type pins,
   output logic carrier_output_enable,
   output logic cpu_reset,
   output logic cpu_run,
   output logic oscillator_run,
   output logic stack_clear,
   output logic instruction_strobe,
   output logic standby,
   output logic [11:0] fetch_address
);

   reset_halt_pkg::sequencer_state_type state;
   reset_halt_pkg::sequencer_state_type next_state;
   logic [2:0] phase;
   logic [2:0] next_phase;
   logic [2:0] pulse_count;
   logic [2:0] next_pulse_count;
   logic tx_previous;
   logic next_tx_previous;

   reset_halt_pkg::output_pins_type next_pins;
   logic next_carrier_output_enable;
   logic next_cpu_reset;
   logic next_cpu_run;
   logic next_oscillator_run;
   logic next_stack_clear;
   logic next_instruction_strobe;
   logic next_standby;

   logic key_active;
   logic instruction_end;
   logic tx_rise;
   logic halt_entry;
   logic auto_clear;
   logic auto_reached;
   logic stab_enable;
   logic stab_reached;
   logic pulse_done;

   localparam logic [2:0] LAST_PHASE = 3'(reset_halt_pkg::INSTR_CLOCKS - 1);
   localparam logic [2:0] LAST_PULSE = 3'(reset_halt_pkg::RESET_PULSE_CLOCKS - 1);

   // Keys are active low; any low line on either group counts as a press.
   function automatic logic any_key(input logic [3:0] group_a, input logic [3:0] group_b);
      any_key = (group_a != 4'hF) || (group_b != 4'hF);
   endfunction

   always_comb begin
      key_active = any_key(key_input_group_a_n, key_input_group_b_n);
      instruction_end = (state == reset_halt_pkg::RUN_STATE) && (phase == LAST_PHASE);
      tx_rise = (state == reset_halt_pkg::RUN_STATE) && tx_activity_bit && !tx_previous;
      // A request is seen once per instruction cycle, and never while a key is down.
      halt_entry = instruction_end && halt_request_bit && !key_active;
      pulse_done = (pulse_count == LAST_PULSE);
      auto_clear = tx_rise || halt_entry || (state == reset_halt_pkg::RESET_STATE);
      stab_enable = (state == reset_halt_pkg::STABILIZE_STATE) && key_active;
   end

   // Auto-reset counter runs only while the CPU executes.
   cycle_counter #(
      .LIMIT(AUTO_RESET_CYCLES)
   ) auto_reset_counter (
      .clock(clock),
      .sys_rst(sys_rst),
      .clear(auto_clear),
      .count_enable(state == reset_halt_pkg::RUN_STATE),
      .reached(auto_reached)
   );

   // Stabilization counter restarts whenever the key lets go.
   cycle_counter #(
      .LIMIT(STAB_CYCLES)
   ) stabilization_counter (
      .clock(clock),
      .sys_rst(sys_rst),
      .clear(!stab_enable),
      .count_enable(stab_enable),
      .reached(stab_reached)
   );

   always_comb begin
      next_state = state;
      next_phase = phase;
      next_pulse_count = pulse_count;
      next_tx_previous = tx_previous;
      case (state)
         reset_halt_pkg::RUN_STATE: begin
            next_tx_previous = tx_activity_bit;
            next_phase = instruction_end ? reset_halt_pkg::PHASE_RESET : phase + 3'h1;
            if (power_on_request) begin
               next_state = reset_halt_pkg::RESET_STATE;
            end else if (auto_reached) begin
               next_state = reset_halt_pkg::RESET_STATE;
            end else if (halt_entry) begin
               next_state = reset_halt_pkg::HALT_STATE;
            end
         end
         reset_halt_pkg::HALT_STATE: begin
            // Phase and edge history stay frozen while the oscillator is stopped.
            if (power_on_request) begin
               next_state = reset_halt_pkg::RESET_STATE;
            end else if (key_active) begin
               next_state = reset_halt_pkg::STABILIZE_STATE;
            end
         end
         reset_halt_pkg::STABILIZE_STATE: begin
            if (power_on_request) begin
               next_state = reset_halt_pkg::RESET_STATE;
            end else if (!key_active) begin
               next_state = reset_halt_pkg::HALT_STATE;
            end else if (stab_reached) begin
               next_state = reset_halt_pkg::RESET_STATE;
            end
         end
         reset_halt_pkg::RESET_STATE: begin
            next_phase = reset_halt_pkg::PHASE_RESET;
            next_tx_previous = tx_activity_bit;
            if (!pulse_done) begin
               next_pulse_count = pulse_count + 3'h1;
            end else if (!power_on_request) begin
               next_pulse_count = reset_halt_pkg::PULSE_RESET;
               next_state = reset_halt_pkg::RUN_STATE;
            end
         end
         default: begin
            next_state = reset_halt_pkg::RESET_STATE;
            next_pulse_count = reset_halt_pkg::PULSE_RESET;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= reset_halt_pkg::RESET_STATE;
         phase <= reset_halt_pkg::PHASE_RESET;
         pulse_count <= reset_halt_pkg::PULSE_RESET;
         tx_previous <= 1'b0;
      end else begin
         state <= next_state;
         phase <= next_phase;
         pulse_count <= next_pulse_count;
         tx_previous <= next_tx_previous;
      end
   end

   // Output stage, registered so every pin comes from a flip-flop.
   always_comb begin
      next_pins = cpu_pins;
      next_carrier_output_enable = 1'b1;
      next_cpu_reset = 1'b0;
      next_cpu_run = 1'b0;
      next_oscillator_run = 1'b1;
      next_stack_clear = 1'b0;
      next_instruction_strobe = 1'b0;
      next_standby = 1'b0;
      case (next_state)
         reset_halt_pkg::RUN_STATE: begin
            next_cpu_run = 1'b1;
            next_instruction_strobe = (next_phase == LAST_PHASE);
         end
         reset_halt_pkg::HALT_STATE, reset_halt_pkg::STABILIZE_STATE: begin
            // LED and option strobe hold what they showed when standby began.
            next_pins = pins;
            next_pins.carrier_output = 1'b0;
            next_pins.individual_strobe_outputs = 4'h0;
            next_pins.parallel_strobe_outputs = 4'h0;
            next_pins.indicator_led_output = pins.indicator_led_output;
            next_pins.option_strobe_output = pins.option_strobe_output;
            next_carrier_output_enable = !CARRIER_FLOATS;
            next_standby = 1'b1;
            // The CPU is frozen in both states; only a key or power_on_request restarts the oscillator.
            next_oscillator_run = (next_state == reset_halt_pkg::STABILIZE_STATE);
         end
         reset_halt_pkg::RESET_STATE: begin
            next_pins = reset_halt_pkg::PINS_LOW;
            next_carrier_output_enable = !CARRIER_FLOATS;
            next_cpu_reset = 1'b1;
            // Only the stack is cleared; page, pointer and accumulator see no clear.
            next_stack_clear = 1'b1;
         end
         default: begin
            next_pins = reset_halt_pkg::PINS_LOW;
            next_cpu_reset = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pins <= reset_halt_pkg::PINS_LOW;
         carrier_output_enable <= !CARRIER_FLOATS;
         cpu_reset <= 1'b1;
         cpu_run <= 1'b0;
         oscillator_run <= 1'b1;
         stack_clear <= 1'b1;
         instruction_strobe <= 1'b0;
         standby <= 1'b0;
         fetch_address <= reset_halt_pkg::RESET_ADDRESS;
      end else begin
         pins <= next_pins;
         carrier_output_enable <= next_carrier_output_enable;
         cpu_reset <= next_cpu_reset;
         cpu_run <= next_cpu_run;
         oscillator_run <= next_oscillator_run;
         stack_clear <= next_stack_clear;
         instruction_strobe <= next_instruction_strobe;
         standby <= next_standby;
         fetch_address <= reset_halt_pkg::RESET_ADDRESS;
      end
   end

endmodule

// [include/reset_halt_pkg.sv]
// Constants and carrier types shared by the reset and standby sequencer.
// Assumes the system clock is the device oscillator and runs at CLOCK_HZ.
package reset_halt_pkg;

   // System clock rate.
   localparam longint CLOCK_HZ = 20000000;

   // Oscillator clocks per instruction cycle.
   localparam int INSTR_CLOCKS = 6;

   // Auto-reset period in oscillator cycles.
   localparam int AUTO_RESET_OSC_CYCLES = 131072;

   // Oscillator stabilization interval after a key wakes the device, in microseconds.
   localparam longint STAB_TIME_US = 9000;

   // Stabilization interval as clock cycles.
   // It is a least time, so it rounds up, and it is never below one cycle.
   localparam longint STAB_CYCLES_RAW = (STAB_TIME_US * CLOCK_HZ + 64'd999999) / 64'd1000000;
   localparam int STAB_CYCLES = (STAB_CYCLES_RAW < 1) ? 1 : int'(STAB_CYCLES_RAW);

   // Reset pulse length in clock cycles: one instruction cycle.
   localparam int RESET_PULSE_CLOCKS = INSTR_CLOCKS;

   // Address from which the CPU fetches after any reset.
   localparam logic [11:0] RESET_ADDRESS = 12'hF00;

   // Reset values.
   localparam logic [2:0] PHASE_RESET = 3'h0;
   localparam logic [2:0] PULSE_RESET = 3'h0;

   // Sequencer states.
   typedef enum logic [1:0] {
      RUN_STATE = 2'b00,
      HALT_STATE = 2'b01,
      STABILIZE_STATE = 2'b10,
      RESET_STATE = 2'b11
   } sequencer_state_type;

   // Output pin group as driven by the CPU and as seen at the pins.
   typedef struct packed {
      logic carrier_output;
      logic indicator_led_output;
      logic option_strobe_output;
      logic [3:0] individual_strobe_outputs;
      logic [3:0] parallel_strobe_outputs;
   } output_pins_type;

   localparam output_pins_type PINS_LOW = '0;

endpackage

// [src/cycle_counter.sv]
// Up-counter that flags the cycle in which it reaches its limit.
// Assumes one synchronous, active-high reset and one clock.
`timescale 1ns/10ps
module cycle_counter #(
   parameter int LIMIT = 4,
   parameter int WIDTH = (LIMIT > 1) ? $clog2(LIMIT) : 1
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic count_enable,
   output logic reached
);

   localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   always_comb begin
      reached = count_enable && (count == LAST);
      if (clear || reached) begin
         next_count = '0;
      end else if (count_enable) begin
         next_count = count + WIDTH'(1);
      end else begin
         next_count = count;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule

// [sim/key_pad_model.sv]
// Key matrix model on the far side of the sequencer.
// Assumes pull-ups on every key line, so released lines read high.
`timescale 1ns/10ps
module key_pad_model (
   input wire logic clock,
   output logic [3:0] key_a_n,
   output logic [3:0] key_b_n
);
   initial begin
      key_a_n = 4'hF;
      key_b_n = 4'hF;
   end
   // Holds one group low for a count of clocks, then the pull-ups win again.
   task automatic press(input bit group_b, input logic [3:0] mask_n, input int cycles);
      if (group_b)
         key_b_n = mask_n;
      else
         key_a_n = mask_n;
      repeat (cycles) @(posedge clock);
      #1;
      key_a_n = 4'hF;
      key_b_n = 4'hF;
   endtask
endmodule

// [sim/seq_checker.sv]
// Port-level checks of the reset and standby sequencer.
// Assumes one clock and the active-high synchronous sys_rst.
`timescale 1ns/10ps
module seq_checker #(
   parameter int AUTO_RESET_CYCLES = 64,
   parameter int STAB_CYCLES = 20
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic power_on_request,
   input wire logic tx_activity_bit,
   input wire logic halt_request_bit,
   input wire logic [3:0] key_input_group_a_n,
   input wire logic [3:0] key_input_group_b_n,
   input wire reset_halt_pkg::output_pins_type pins,
   input wire logic cpu_reset,
   input wire logic cpu_run,
   input wire logic oscillator_run,
   input wire logic stack_clear,
   input wire logic instruction_strobe,
   input wire logic standby
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire logic key_on = ~&{key_input_group_a_n, key_input_group_b_n};
   logic tx_last;
   int run_count;
   int stab_count;
   // Cycles of running since the last activity rise, and of held keys while waking.
   always_ff @(posedge clock) begin
      tx_last <= tx_activity_bit;
      if (sys_rst || !cpu_run || (tx_activity_bit && !tx_last))
         run_count <= 0;
      else
         run_count <= run_count + 1;
      if (sys_rst || !(standby && oscillator_run && key_on))
         stab_count <= 0;
      else
         stab_count <= stab_count + 1;
   end
   // The request is taken on the last clock of an instruction, which the strobe marks.
   sequence s_halt_ask;
      cpu_run && instruction_strobe && halt_request_bit && !key_on && !power_on_request;
   endsequence
   property p_halt_enter;
      s_halt_ask |=> standby && !oscillator_run && !cpu_run;
   endproperty
   property p_halt_refuse;
      cpu_run && halt_request_bit && key_on && !power_on_request |=> !standby;
   endproperty
   property p_frozen;
      !oscillator_run |-> standby && !cpu_run && pins.carrier_output == 1'b0 &&
         pins.individual_strobe_outputs == 4'h0 && pins.parallel_strobe_outputs == 4'h0;
   endproperty
   property p_hold;
      standby |-> $stable(pins.indicator_led_output) && $stable(pins.option_strobe_output);
   endproperty
   property p_wake;
      !oscillator_run && key_on && !power_on_request |=> oscillator_run && standby && !cpu_reset;
   endproperty
   property p_stab_early;
      $rose(cpu_reset) && $past(standby) && !$past(power_on_request) |->
         stab_count >= STAB_CYCLES - 1;
   endproperty
   property p_stab_late;
      stab_count <= STAB_CYCLES + 1;
   endproperty
   property p_auto_early;
      $rose(cpu_reset) && $past(cpu_run) && !$past(power_on_request) |->
         run_count >= AUTO_RESET_CYCLES - 3;
   endproperty
   property p_auto_late;
      run_count <= AUTO_RESET_CYCLES + 2;
   endproperty
   property p_pulse;
      $rose(cpu_reset) |-> cpu_reset [*6];
   endproperty
   property p_reset_out;
      cpu_reset |-> stack_clear && !cpu_run && pins == reset_halt_pkg::PINS_LOW;
   endproperty
   property p_instr;
      instruction_strobe |-> cpu_run ##1 !instruction_strobe [*5];
   endproperty
   a_halt_enter: assert property (p_halt_enter) else $error("halt missed");
   a_halt_refuse: assert property (p_halt_refuse) else $error("halt taken");
   a_frozen: assert property (p_frozen) else $error("halt state");
   a_hold: assert property (p_hold) else $error("pin moved");
   a_wake: assert property (p_wake) else $error("no wake");
   a_stab_early: assert property (p_stab_early) else $error("wake early");
   a_stab_late: assert property (p_stab_late) else $error("wake late");
   a_auto_early: assert property (p_auto_early) else $error("auto early");
   a_auto_late: assert property (p_auto_late) else $error("auto late");
   a_pulse: assert property (p_pulse) else $error("pulse short");
   a_reset_out: assert property (p_reset_out) else $error("reset outs");
   a_instr: assert property (p_instr) else $error("strobe gap");
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the reset and standby sequencer.
// Assumes the package, the design, the key model and the checker are compiled first.
`timescale 1ns/10ps
module tb_top;
   localparam int AUTO = 64;
   localparam int STAB = 20;
   logic clock, sys_rst, power_on_request, tx_activity_bit, halt_request_bit;
   logic cpu_reset, cpu_run, oscillator_run, stack_clear, instruction_strobe, standby, c_oe;
   logic float_oe;
   logic [3:0] key_a_n, key_b_n;
   logic [11:0] fetch_address;
   reset_halt_pkg::output_pins_type cpu_pins, pins;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   reset_halt_sequencer #(.AUTO_RESET_CYCLES(AUTO), .STAB_CYCLES(STAB)) DUT (.clock, .sys_rst,
      .power_on_request, .tx_activity_bit, .halt_request_bit, .key_input_group_a_n(key_a_n),
      .key_input_group_b_n(key_b_n), .cpu_pins, .pins, .carrier_output_enable(c_oe),
      .cpu_reset, .cpu_run, .oscillator_run, .stack_clear, .instruction_strobe, .standby,
      .fetch_address);
   key_pad_model keys (.clock, .key_a_n, .key_b_n);
   // Second copy in the floating-carrier variant; the bench reads only its carrier enable, the bound checker sees the rest.
   reset_halt_sequencer #(.CARRIER_FLOATS(1'b1), .AUTO_RESET_CYCLES(AUTO), .STAB_CYCLES(STAB))
      float_dut (.clock, .sys_rst, .power_on_request, .tx_activity_bit, .halt_request_bit,
      .key_input_group_a_n(key_a_n), .key_input_group_b_n(key_b_n), .cpu_pins, .pins(),
      .carrier_output_enable(float_oe), .cpu_reset(), .cpu_run(), .oscillator_run(),
      .stack_clear(), .instruction_strobe(), .standby(), .fetch_address());
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic tick(input int k = 1);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_level(ref logic sig, input logic lvl, input int limit);
      n = 0;
      while (sig !== lvl && n < limit) begin
         tick();
         n++;
      end
   endtask
   // Firmware keep-alive: activity bit low, then high.
   task automatic kick();
      tx_activity_bit = 1'b0;
      tick();
      tx_activity_bit = 1'b1;
      tick();
   endtask
   task automatic results();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         results();
      end
   end
   initial begin
      sys_rst = 1'b1;
      power_on_request = 1'b0;
      tx_activity_bit = 1'b0;
      halt_request_bit = 1'b0;
      cpu_pins = 11'h7FF;
      tick(3);
      check("reset pins", 12'(pins), 12'h000);
      check("reset flags", 12'({cpu_reset, stack_clear, c_oe, float_oe}), 12'h00E);
      sys_rst = 1'b0;
      wait_level(cpu_run, 1'b1, 20);
      check("fetch", fetch_address, reset_halt_pkg::RESET_ADDRESS);
      tick(2);
      check("run pins", 12'(pins), 12'h7FF);
      check("run oe", 12'({c_oe, float_oe}), 12'h003);
      wait_level(instruction_strobe, 1'b1, 8);
      tick();
      wait_level(instruction_strobe, 1'b1, 8);
      check("instr gap", 12'(n), 12'h005);
      repeat (6) begin
         kick();
         tick(AUTO - 20);
         check("alive", 12'(cpu_run), 12'h001);
      end
      kick();
      wait_level(cpu_reset, 1'b1, AUTO + 20);
      check("auto time", 12'(n >= AUTO - 4 && n <= AUTO + 2), 12'h001);
      wait_level(cpu_reset, 1'b0, 20);
      check("pulse", 12'(n), 12'h006);
      wait_level(cpu_run, 1'b1, 20);
      kick();
      fork
         keys.press(1'b0, 4'hE, 14);
         begin
            halt_request_bit = 1'b1;
            tick(12);
            halt_request_bit = 1'b0;
         end
      join
      check("refused", 12'(standby), 12'h000);
      kick();
      halt_request_bit = 1'b1;
      wait_level(standby, 1'b1, 8);
      halt_request_bit = 1'b0;
      cpu_pins = 11'h000;
      tick(2);
      check("halt pins", 12'(pins), 12'h300);
      check("halt osc", 12'({oscillator_run, cpu_run}), 12'h000);
      check("halt oe", 12'({c_oe, float_oe}), 12'h002);
      keys.press(1'b1, 4'h7, STAB - 6);
      tick(4);
      check("short key", 12'({standby, oscillator_run, cpu_reset}), 12'h004);
      cpu_pins = 11'h7FF;
      fork
         keys.press(1'b1, 4'hB, STAB + 12);
         begin
            wait_level(cpu_reset, 1'b1, STAB + 10);
            check("stab time", 12'(n >= STAB && n <= STAB + 2), 12'h001);
            check("wake pins", 12'(pins), 12'h000);
            check("wake flags", 12'({stack_clear, standby}), 12'h002);
         end
      join
      wait_level(cpu_run, 1'b1, 20);
      check("wake fetch", fetch_address, reset_halt_pkg::RESET_ADDRESS);
      power_on_request = 1'b1;
      tick(10);
      check("por held", 12'(cpu_reset), 12'h001);
      power_on_request = 1'b0;
      wait_level(cpu_run, 1'b1, 20);
      check("por end", 12'(cpu_run), 12'h001);
      results();
   end
endmodule
bind reset_halt_sequencer seq_checker #(.AUTO_RESET_CYCLES(AUTO_RESET_CYCLES),
   .STAB_CYCLES(STAB_CYCLES)) chk (.clock, .sys_rst, .power_on_request, .tx_activity_bit,
   .halt_request_bit, .key_input_group_a_n, .key_input_group_b_n, .pins, .cpu_reset, .cpu_run,
   .oscillator_run, .stack_clear, .instruction_strobe, .standby);
